// [hw/addr_phase_proc.sv]
// Processor end of the system bus address phase.
// What this block does
// - Address with strobe low, type with strobe high.
// - Upper parity covers 35:24, lower covers 23:3.
// - Capture address lines as configuration at reset release.
// - Force address bit 20 off while mask asserted.
// - Mask asserted only in real mode.
// - Mask sampled as the request is taken; target ready is not used.
// - Strobe marks address valid, starts checking.
// - All agents drive and observe parity error.
// - Abort on parity error when observation enabled.
// - Central agent handles error when observation disabled.
// - Parity driven with strobe, address, type, request parity.
// - Address parity high when even count of low lines; request parity high when odd count.
// - Launch and capture on rising bus clock edge.
`timescale 1ns/1ns
`include "addr_phase_defines.svh"
module addr_phase_proc
  import addr_phase_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  addr_phase_if.proc_end bus,
  input wire logic req_valid,
  input wire bus_addr_t req_addr,
  input wire logic [`REQ_TYPE_W-1:0] req_type,
  input wire bus_addr_t req_type_info,
  input wire logic corrupt_parity,
  output logic req_ready,
  output logic req_aborted,
  output logic parity_error_seen,
  output bus_addr_t power_on_config,
  output logic config_valid
);
  issue_state_t state;
  issue_state_t next_state;
  bus_addr_t held_addr;
  bus_addr_t held_info;
  logic [`REQ_TYPE_W-1:0] held_type;
  logic rst_seen;
  logic check_pending;
  bus_addr_t rx_addr;
  logic [1:0] rx_par;
  logic mask_on;
  logic upper_par_n;
  logic lower_par_n;
  logic rx_upper_ok;
  logic rx_lower_ok;
  logic observe_enabled;
  logic err_valid;
  bus_addr_t masked_addr;
  bus_addr_t drive_addr;
  bus_addr_t next_drive;
  logic held_corrupt;
  logic take;
  logic addr_cycle;
  logic bus_busy;
  logic rx_mismatch;

  assign take = req_valid && req_ready;
  assign addr_cycle = (state == st_addr);
  assign bus_busy = (state != st_idle);
  assign mask_on = !bus.addr_bit20_mask_n;
  assign masked_addr = mask_on ?
    (req_addr & ~(33'h0_0000_0001 << (`MASK_BIT - `ADDR_LSB))) :
    req_addr;
  // A true address bit of one is a low line, so parity is high for an
  // even count of ones in the true address.
  // A set held_corrupt flips the lower bit so a fault can be injected.
  assign upper_par_n = ~^held_addr[`ADDR_MSB-`ADDR_LSB:
    `UPPER_PAR_LSB-`ADDR_LSB];
  assign lower_par_n = (~^held_addr[`LOWER_PAR_MSB-`ADDR_LSB:0]) ^
    held_corrupt;
  assign rx_upper_ok = (~^(~rx_addr[`ADDR_MSB-`ADDR_LSB:
    `UPPER_PAR_LSB-`ADDR_LSB])) == rx_par[1];
  assign rx_lower_ok = (~^(~rx_addr[`LOWER_PAR_MSB-`ADDR_LSB:0])) ==
    rx_par[0];
  assign rx_mismatch = check_pending && !(rx_upper_ok && rx_lower_ok);
  assign observe_enabled = power_on_config[`CFG_PAR_OBSERVE_BIT];
  assign err_valid = !bus.address_parity_error_n && !bus.proc_err_oe;
  assign req_ready = (state == st_idle);
  assign next_drive = addr_cycle ? held_addr : held_info;

  always_comb
  begin
    next_state = state;
    unique case (state)
      st_idle: if (req_valid) next_state = st_addr;
      st_addr: next_state = st_type;
      st_type: next_state = st_idle;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      state <= st_idle;
    else
      state <= next_state;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      held_addr <= '0;
      held_info <= '0;
      held_type <= '0;
    end
    else if (take)
    begin
      held_addr <= masked_addr;
      held_info <= req_type_info;
      held_type <= req_type;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      held_corrupt <= 1'b0;
    else if (take)
      held_corrupt <= corrupt_parity;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bus.proc_addr_oe <= 1'b0;
      bus.proc_strobe_n <= 1'b1;
      bus.proc_addr_n <= '1;
      bus.proc_par_n <= 2'b11;
      bus.proc_req_n <= '1;
      bus.proc_req_par_n <= 1'b1;
    end
    else
    begin
      bus.proc_addr_oe <= bus_busy;
      bus.proc_strobe_n <= !addr_cycle;
      bus.proc_addr_n <= ~next_drive;
      bus.proc_par_n <= {upper_par_n, lower_par_n};
      bus.proc_req_n <= ~held_type;
      bus.proc_req_par_n <= ^held_type;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_seen <= 1'b0;
      config_valid <= 1'b0;
      power_on_config <= '0;
    end
    else
    begin
      rst_seen <= 1'b1;
      if (!rst_seen)
      begin
        power_on_config <= ~bus.addr_n;
        config_valid <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      check_pending <= 1'b0;
      rx_addr <= '0;
      rx_par <= 2'b11;
    end
    else
    begin
      check_pending <= !bus.address_strobe_n && !bus.proc_addr_oe;
      rx_addr <= bus.addr_n;
      rx_par <= bus.address_parity_bits_n;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bus.proc_err_n <= 1'b1;
      bus.proc_err_oe <= 1'b0;
    end
    else
    begin
      bus.proc_err_oe <= rx_mismatch;
      bus.proc_err_n <= !rx_mismatch;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      parity_error_seen <= 1'b0;
      req_aborted <= 1'b0;
    end
    else
    begin
      parity_error_seen <= err_valid;
      req_aborted <= err_valid && observe_enabled;
    end
  end
endmodule : addr_phase_proc

// [hw/addr_phase_defines.svh]
// Constants for the system bus address phase.
`ifndef ADDR_PHASE_DEFINES_SVH
`define ADDR_PHASE_DEFINES_SVH
`define ADDR_MSB 35
`define ADDR_LSB 3
`define ADDR_W 33
`define UPPER_PAR_LSB 24
`define LOWER_PAR_MSB 23
`define MASK_BIT 20
`define REQ_TYPE_W 5
`define CFG_PAR_OBSERVE_BIT 7
`endif

// [hw/addr_phase_pkg.sv]
// Types for the system bus address phase.
package addr_phase_pkg;
  typedef logic [32:0] bus_addr_t;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_addr = 2'b01,
    st_type = 2'b10
  } issue_state_t;
endpackage : addr_phase_pkg

// [hw/addr_phase_if.sv]
// Shared address phase wires between the processor end and the agent end.
`timescale 1ns/1ns
interface addr_phase_if;
  logic [32:0] proc_addr_n;
  logic proc_addr_oe;
  logic proc_strobe_n;
  logic [1:0] proc_par_n;
  logic [4:0] proc_req_n;
  logic proc_req_par_n;
  logic proc_err_n;
  logic proc_err_oe;
  logic [32:0] agent_addr_n;
  logic agent_addr_oe;
  logic agent_strobe_n;
  logic agent_strobe_oe;
  logic [1:0] agent_par_n;
  logic agent_err_n;
  logic agent_err_oe;
  logic addr_bit20_mask_n;
  logic target_ready_n;
  logic [32:0] addr_n;
  logic address_strobe_n;
  logic [1:0] address_parity_bits_n;
  logic address_parity_error_n;
  assign addr_n = proc_addr_oe ? proc_addr_n :
                  agent_addr_oe ? agent_addr_n : '1;
  assign address_strobe_n = proc_addr_oe ? proc_strobe_n :
                            agent_strobe_oe ? agent_strobe_n : 1'b1;
  assign address_parity_bits_n = proc_addr_oe ? proc_par_n :
                                 agent_addr_oe ? agent_par_n : 2'b11;
  assign address_parity_error_n = (proc_err_oe ? proc_err_n : 1'b1) &
                                  (agent_err_oe ? agent_err_n : 1'b1);
  modport proc_end (
    output proc_addr_n, proc_addr_oe, proc_strobe_n, proc_par_n,
    output proc_req_n, proc_req_par_n, proc_err_n, proc_err_oe,
    input addr_n, address_strobe_n, address_parity_bits_n,
    input address_parity_error_n, addr_bit20_mask_n, target_ready_n
  );
  modport agent_end (
    output agent_addr_n, agent_addr_oe, agent_strobe_n, agent_strobe_oe,
    output agent_par_n, agent_err_n, agent_err_oe,
    output addr_bit20_mask_n, target_ready_n,
    input addr_n, address_strobe_n, address_parity_bits_n,
    input address_parity_error_n
  );
endinterface : addr_phase_if

// [hw/addr_phase_agent.sv]
// Chipset agent end of the system bus address phase.
`timescale 1ns/1ns
`include "addr_phase_defines.svh"
module addr_phase_agent
  import addr_phase_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  addr_phase_if.agent_end bus,
  input wire bus_addr_t config_strap,
  input wire logic real_mode_mask,
  input wire logic io_write_done,
  input wire logic send_valid,
  input wire bus_addr_t send_addr,
  input wire logic corrupt_parity,
  output logic observed_valid,
  output bus_addr_t observed_addr,
  output logic observed_error
);
  logic strap_drive;
  logic strobe_q;
  logic par_ok;
  bus_addr_t send_q;
  logic send_q_valid;
  logic send_bad;

  // Low-active parity: high when an even number of covered lines are low.
  assign par_ok = (~^(~bus.addr_n[`ADDR_MSB-`ADDR_LSB:
    `UPPER_PAR_LSB-`ADDR_LSB]) == bus.address_parity_bits_n[1]) &&
    (~^(~bus.addr_n[`LOWER_PAR_MSB-`ADDR_LSB:0]) ==
    bus.address_parity_bits_n[0]);
  assign strobe_q = !bus.address_strobe_n && !bus.agent_strobe_oe;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strap_drive <= 1'b1;
      send_q <= '0;
      send_q_valid <= 1'b0;
      send_bad <= 1'b0;
    end
    else
    begin
      strap_drive <= 1'b0;
      send_q_valid <= send_valid && !strap_drive;
      send_q <= send_addr;
      send_bad <= corrupt_parity;
    end
  end

  always_comb
  begin
    bus.agent_addr_oe = strap_drive || send_q_valid;
    bus.agent_addr_n = strap_drive ? ~config_strap : ~send_q;
    bus.agent_strobe_oe = send_q_valid;
    bus.agent_strobe_n = !send_q_valid;
    bus.agent_par_n = {~^send_q[`ADDR_MSB-`ADDR_LSB:
      `UPPER_PAR_LSB-`ADDR_LSB],
      (~^send_q[`LOWER_PAR_MSB-`ADDR_LSB:0]) ^ send_bad};
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bus.addr_bit20_mask_n <= 1'b1;
      bus.target_ready_n <= 1'b1;
      bus.agent_err_n <= 1'b1;
      bus.agent_err_oe <= 1'b0;
      observed_valid <= 1'b0;
      observed_addr <= '0;
      observed_error <= 1'b0;
    end
    else
    begin
      bus.addr_bit20_mask_n <= !real_mode_mask;
      bus.target_ready_n <= !io_write_done;
      bus.agent_err_oe <= strobe_q && !par_ok;
      bus.agent_err_n <= !(strobe_q && !par_ok);
      observed_valid <= strobe_q;
      observed_addr <= ~bus.addr_n;
      observed_error <= !bus.address_parity_error_n;
    end
  end
endmodule : addr_phase_agent

// [tb/addr_phase_assertions.sv]
// Protocol assertions on the shared address phase wires.
`timescale 1ns/1ns
module addr_phase_assertions (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [32:0] addr_n,
  input wire logic address_strobe_n,
  input wire logic [1:0] address_parity_bits_n,
  input wire logic addr_bit20_mask_n,
  input wire logic proc_addr_oe,
  input wire logic proc_strobe_n,
  input wire logic proc_err_n,
  input wire logic proc_err_oe,
  input wire logic agent_err_n,
  input wire logic agent_err_oe,
  input wire logic parity_inject
);
  wire par_ok = (address_parity_bits_n[1] == ~^addr_n[32:21]) &&
    (address_parity_bits_n[0] == ^addr_n[20:0]);
  wire p_go = proc_addr_oe && !proc_strobe_n;
  wire g_go = !address_strobe_n && !proc_addr_oe;
  wire p_err = proc_err_oe && !proc_err_n;
  wire g_err = agent_err_oe && !agent_err_n;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_upper_par_ok: assert property (p_go |->
    address_parity_bits_n[1] == ~^addr_n[32:21]) else $error("upper parity");
  a_lower_par_ok: assert property (p_go && !parity_inject |->
    address_parity_bits_n[0] == ^addr_n[20:0]) else $error("lower parity");
  a_type_follows: assert property (p_go |=>
    proc_addr_oe && proc_strobe_n) else $error("no type cycle");
  a_release_after: assert property (proc_addr_oe && proc_strobe_n |=>
    !proc_addr_oe) else $error("bus not released");
  a_mask_bit20: assert property (p_go &&
    $past(!addr_bit20_mask_n, 3) |-> addr_n[17])
    else $error("bit 20 not masked");
  a_agent_quiet: assert property (p_go && par_ok |=> !g_err)
    else $error("agent false parity error");
  a_agent_flags: assert property (p_go && !par_ok |=> g_err)
    else $error("agent missed parity error");
  a_proc_flags: assert property (g_go && !par_ok |-> ##2 p_err)
    else $error("processor missed parity error");
  a_proc_quiet: assert property (g_go && par_ok |-> ##2 !p_err)
    else $error("processor false parity error");
endmodule : addr_phase_assertions

// [tb/tb_top.sv]
// Testbench joining the processor end and the agent end.
`timescale 1ns/1ns
module tb_top;
  import addr_phase_pkg::*;
  logic clock = 0, rst_b = 0, req_valid = 0, real_mode_mask = 0;
  logic io_write_done = 0, send_valid = 0, proc_corrupt = 0;
  logic agent_corrupt = 0;
  logic [4:0] req_type = 5'h15;
  bus_addr_t req_addr = '0, req_type_info = '0, send_addr = '0;
  bus_addr_t config_strap = 33'h1_2345_6789;
  logic req_ready, req_aborted, parity_error_seen, config_valid;
  logic observed_valid, observed_error;
  bus_addr_t power_on_config, observed_addr;
  int error_cnt = 0, checks = 0;
  addr_phase_if bus_if ();
  addr_phase_proc u_addr_phase_proc (.clock, .rst_b, .bus(bus_if),
    .req_valid, .req_addr, .req_type, .req_type_info, .req_ready,
    .req_aborted, .parity_error_seen, .power_on_config, .config_valid,
    .corrupt_parity(proc_corrupt));
  addr_phase_agent u_addr_phase_agent (.clock, .rst_b, .bus(bus_if),
    .config_strap, .real_mode_mask, .io_write_done, .send_valid,
    .send_addr, .observed_valid, .observed_addr, .observed_error,
    .corrupt_parity(agent_corrupt));
  addr_phase_assertions u_addr_phase_assertions (.clock(clock),
    .rst_b(rst_b), .addr_n(bus_if.addr_n),
    .address_strobe_n(bus_if.address_strobe_n),
    .address_parity_bits_n(bus_if.address_parity_bits_n),
    .addr_bit20_mask_n(bus_if.addr_bit20_mask_n),
    .proc_addr_oe(bus_if.proc_addr_oe),
    .proc_strobe_n(bus_if.proc_strobe_n),
    .proc_err_n(bus_if.proc_err_n), .proc_err_oe(bus_if.proc_err_oe),
    .agent_err_n(bus_if.agent_err_n), .agent_err_oe(bus_if.agent_err_oe),
    .parity_inject(proc_corrupt));

  initial
  begin
    forever #25 clock = ~clock;
  end

  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic cmp(input bus_addr_t got, input bus_addr_t exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // Issues one request and checks both cycles on the wires.
  task automatic issue(input bus_addr_t a, input bus_addr_t t,
                       input bus_addr_t e, input logic bad);
    int n;
    cmp(bus_addr_t'(req_ready), 33'h0_0000_0001);
    req_valid = 1;
    req_addr = a;
    req_type_info = t;
    proc_corrupt = bad;
    @(negedge clock);
    req_valid = 0;
    n = 0;
    while (bus_if.address_strobe_n !== 1'b0 && n < 8)
    begin
      @(negedge clock);
      n++;
    end
    if (bus_if.address_strobe_n !== 1'b0)
    begin
      error_cnt++;
      stop_test;
    end
    cmp(~bus_if.addr_n, e);
    cmp(bus_addr_t'(bus_if.address_parity_bits_n),
      bus_addr_t'({~^e[32:21], (~^e[20:0]) ^ bad}));
    cmp(bus_addr_t'(bus_if.proc_req_n ^ req_type), 33'h0_0000_001f);
    @(negedge clock);
    cmp(~bus_if.addr_n, t);
    n = 0;
    while (observed_valid !== 1'b1 && n < 4)
    begin
      @(negedge clock);
      n++;
    end
    if (observed_valid !== 1'b1)
    begin
      error_cnt++;
      stop_test;
    end
    cmp(observed_addr, e);
    cmp(bus_addr_t'(observed_error), 33'h0_0000_0000);
    @(negedge clock);
    cmp(bus_addr_t'(observed_error), bus_addr_t'(bad));
    cmp(bus_addr_t'(parity_error_seen), bus_addr_t'(bad));
    cmp(bus_addr_t'(req_aborted), bus_addr_t'(bad & config_strap[7]));
    proc_corrupt = 0;
    repeat (3) @(negedge clock);
  endtask : issue

  task automatic mask_test;
    real_mode_mask = 1;
    io_write_done = 1;
    repeat (3) @(negedge clock);
    issue(33'h0_0003_1234, 33'h0_0000_0011, 33'h0_0001_1234, 1'b0);
    real_mode_mask = 0;
    io_write_done = 0;
    repeat (3) @(negedge clock);
  endtask : mask_test

  task automatic send_test(input logic bad);
    send_valid = 1;
    send_addr = 33'h1_0f0f_0f0f;
    agent_corrupt = bad;
    @(negedge clock);
    send_valid = 0;
    @(negedge clock);
    cmp(bus_addr_t'(bus_if.address_parity_error_n),
      33'h0_0000_0001);
    @(negedge clock);
    cmp(bus_addr_t'(bus_if.address_parity_error_n),
      bus_addr_t'(!bad));
    cmp(bus_addr_t'(bus_if.proc_err_oe), bus_addr_t'(bad));
    @(negedge clock);
    cmp(bus_addr_t'(observed_error), bus_addr_t'(bad));
    cmp(bus_addr_t'(parity_error_seen), 33'h0_0000_0000);
    cmp(bus_addr_t'(req_aborted), 33'h0_0000_0000);
    agent_corrupt = 0;
    repeat (3) @(negedge clock);
  endtask : send_test

  initial
  begin
    repeat (5) @(negedge clock);
    rst_b = 1;
    repeat (2) @(negedge clock);
    cmp(power_on_config, config_strap);
    cmp(bus_addr_t'(config_valid), 33'h0_0000_0001);
    issue(33'h1_ffff_ffff, 33'h0_0000_0007, 33'h1_ffff_ffff, 1'b0);
    issue(33'h0_8421_0843, 33'h1_5555_aaaa, 33'h0_8421_0843, 1'b0);
    mask_test();
    issue(33'h0_0f0f_1234, 33'h0_0000_0003, 33'h0_0f0f_1234, 1'b1);
    send_test(1'b0);
    send_test(1'b1);
    stop_test;
  end
endmodule : tb_top
